// ---- common/flash_ctl_map.svh ----
// offsets, field positions and reset values of the flash control block
// assumes: included by bare name wherever a register or field is decoded
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH

// register offsets on the byte-wide register port
`define CTL0_ADDR     16'h01b7
`define CTL1_ADDR     16'h01b5
`define IRQ_STAT_ADDR 16'h01b8
`define IRQ_MASK_ADDR 16'h01b9

// reset values
`define CTL0_RESET    8'h01
`define CTL1_RESET    8'h00
`define MASK_RESET    3'h0
`define LOCK_RESET    8'hff

// flash_control_0 fields
`define B_READY       0
`define B_REWRITE     1
`define B_LOCK_OFF    2
`define B_STOP        3
`define B_RSVD        4
`define B_USER_AREA   5
`define B_PROG_ERR    6
`define B_ERASE_ERR   7

// flash_control_1 field
`define B_MODE_ONE    1

// interrupt event positions
`define EV_DONE       0
`define EV_PROG       1
`define EV_ERASE      2
`define EV_W          3

`endif

// ---- common/flash_ctl_pkg.sv ----
// types shared by the flash control block
// assumes: compiled before the interface and the design modules
package flash_ctl_pkg;

  // command kinds that reach the flash sequencer
  typedef enum logic [1:0] {
    OP_PROGRAM   = 2'h0,
    OP_ERASE     = 2'h1,
    OP_LOCK_PROG = 2'h2,
    OP_LOCK_READ = 2'h3
  } op_kind_t;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } seq_state_t;

endpackage : flash_ctl_pkg

// ---- common/flash_op_if.sv ----
// carrier between the register block and the flash sequencer
// assumes: flash_ctl_pkg compiled first
`timescale 1ns/10ps
interface flash_op_if;
  import flash_ctl_pkg::*;
  logic       go;          // command accepted by the register side
  op_kind_t   kind;        // requested command
  logic [2:0] blk;         // requested block
  logic       lock_off;    // lock protection ignored
  logic       stop;        // flash stopped
  logic       op_done;     // array finished an operation
  logic       op_fail;     // array reports failure with op_done
  logic       ready;       // sequencer idle
  logic       prog_err;    // last program ended in error
  logic       erase_err;   // last erase ended in error
  logic       lock_result; // block state from last lock read
  logic       start;       // pulse that starts the array
  op_kind_t   cur_kind;    // operation in flight
  logic [2:0] cur_blk;     // block in flight
  logic [2:0] ev;          // one-cycle event pulses

  modport ctl (output go, kind, blk, lock_off, stop, op_done, op_fail,
               input ready, prog_err, erase_err, lock_result, start,
               cur_kind, cur_blk, ev);
  modport seq (input go, kind, blk, lock_off, stop, op_done, op_fail,
               output ready, prog_err, erase_err, lock_result, start,
               cur_kind, cur_blk, ev);
endinterface : flash_op_if

// ---- design/flash_control_status_register.sv ----
// flash rewrite controller: control/status registers and command gating
// assumes: byte register port with read data one cycle after the strobe;
// the flash array returns one op_done per op_start
//
// Summary of operation
// - bit 0 reads 0 while an operation runs, 1 when ready.
// - commands accepted only while rewrite enable is 1; writing 0 disables.
// - lock bits honoured when lock-disable is 0, ignored when 1.
// - stop bit halts flash, low power, control circuits reinitialised.
// - in boot mode, area select 0 routes boot area, 1 user area.
// - program and erase error flags read 1 after a failing operation.
// - lock program and lock read also show busy.
// - all flash array accesses blocked while stop bit is 1.
// - erase with lock protection off unlocks the block when it completes without failure.
// - mode-select bit 0 selects erase-write mode zero, 1 mode one.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "flash_ctl_map.svh"
module flash_control_status_register (
  input  wire logic                    core_clk_in,   // 250 MHz system clock
  input  wire logic                    rst_in,        // async reset, high
  input  wire logic [15:0]             addr_in,       // register address
  input  wire logic [7:0]              wr_data_in,    // write data
  input  wire logic                    wr_en_in,      // write strobe
  input  wire logic                    rd_en_in,      // read strobe
  output logic      [7:0]              rd_data_out,   // read data, next cycle
  output logic                         irq_out,       // level interrupt
  input  wire logic                    boot_mode_in,  // device in boot mode
  input  wire logic                    cmd_valid_in,  // flash command issued
  input  wire flash_ctl_pkg::op_kind_t cmd_kind_in,   // command kind
  input  wire logic [2:0]              cmd_block_in,  // target block
  input  wire logic                    op_done_in,    // array finished
  input  wire logic                    op_fail_in,    // array failure
  output logic                         op_start_out,  // start pulse to array
  output flash_ctl_pkg::op_kind_t      op_kind_out,   // operation in flight
  output logic      [2:0]              op_block_out,  // block in flight
  output logic                         flash_stop_out,       // low power, reset
  output logic                         flash_access_en_out,  // array reachable
  output logic                         user_area_route_out,  // user area routed
  output logic                         rewrite_mode_out,     // rewrite enabled
  output logic                         lock_off_out,         // locks ignored
  output logic                         mode_one_out,         // erase-write one
  output logic                         lock_result_out       // last lock read
);
  import flash_ctl_pkg::*;

  flash_op_if op ();

  logic       rewrite_r, rewrite_nxt;
  logic       lock_off_r, lock_off_nxt;
  logic       stop_r, stop_nxt;
  logic       area_r, area_nxt;
  logic       mode_one_r, mode_one_nxt;
  logic       arm_rw_r, arm_rw_nxt;     // last write put 0 in rewrite enable
  logic       arm_lk_r, arm_lk_nxt;     // last write put 0 in lock-disable
  logic       arm_md_r, arm_md_nxt;     // last write put 0 in mode select
  logic [2:0] mask_r, mask_nxt;
  logic [7:0] rd_data_nxt;
  logic       access_en_r, access_en_nxt;
  logic       route_r, route_nxt;
  logic       wr_ctl0, wr_ctl1, wr_mask, rd_stat;
  logic [2:0] status;
  logic [7:0] ctl0_view;

  // reset image of control_0; the ready bit itself lives in the sequencer
  localparam logic [7:0] ctl0_init = `CTL0_RESET;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb begin
    wr_ctl0 = 1'b0;
    wr_ctl1 = 1'b0;
    wr_mask = 1'b0;
    rd_stat = 1'b0;
    if (addr_in == `CTL0_ADDR) begin
      wr_ctl0 = wr_en_in;
    end else if (addr_in == `CTL1_ADDR) begin
      wr_ctl1 = wr_en_in;
    end else if (addr_in == `IRQ_MASK_ADDR) begin
      wr_mask = wr_en_in;
    end else if (addr_in == `IRQ_STAT_ADDR) begin
      rd_stat = rd_en_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control bits; a 1 lands in rewrite, lock-disable and mode select only right after a 0 was written, stop and area take it directly
  always_comb begin
    rewrite_nxt  = rewrite_r;
    lock_off_nxt = lock_off_r;
    stop_nxt     = stop_r;
    area_nxt     = area_r;
    mode_one_nxt = mode_one_r;
    arm_rw_nxt   = arm_rw_r;
    arm_lk_nxt   = arm_lk_r;
    arm_md_nxt   = arm_md_r;
    mask_nxt     = mask_r;
    if (wr_ctl0) begin
      // an interrupt between the two writes is not visible here
      arm_rw_nxt = ~wr_data_in[`B_REWRITE];
      if (!wr_data_in[`B_REWRITE]) begin
        rewrite_nxt = 1'b0;
      end else if (arm_rw_r) begin
        rewrite_nxt = 1'b1;
      end
      arm_lk_nxt = ~wr_data_in[`B_LOCK_OFF];
      if (!wr_data_in[`B_LOCK_OFF]) begin
        lock_off_nxt = 1'b0;
      end else if (arm_lk_r && rewrite_r) begin
        lock_off_nxt = 1'b1;
      end
      stop_nxt = wr_data_in[`B_STOP];
      area_nxt = wr_data_in[`B_USER_AREA];
    end
    if (wr_ctl1) begin
      arm_md_nxt = ~wr_data_in[`B_MODE_ONE];
      if (!wr_data_in[`B_MODE_ONE]) begin
        mode_one_nxt = 1'b0;
      end else if (arm_md_r && rewrite_r) begin
        mode_one_nxt = 1'b1;
      end
    end
    if (wr_mask) begin
      mask_nxt = wr_data_in[`EV_W-1:0];
    end
    access_en_nxt = ~stop_nxt;
    route_nxt     = ~boot_mode_in | area_nxt;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rewrite_r   <= ctl0_init[`B_REWRITE];
      lock_off_r  <= 1'b0;
      stop_r      <= 1'b0;
      area_r      <= 1'b0;
      mode_one_r  <= 1'b0;
      arm_rw_r    <= 1'b0;
      arm_lk_r    <= 1'b0;
      arm_md_r    <= 1'b0;
      mask_r      <= `MASK_RESET;
      access_en_r <= 1'b1;
      route_r     <= 1'b0;
    end else begin
      rewrite_r   <= rewrite_nxt;
      lock_off_r  <= lock_off_nxt;
      stop_r      <= stop_nxt;
      area_r      <= area_nxt;
      mode_one_r  <= mode_one_nxt;
      arm_rw_r    <= arm_rw_nxt;
      arm_lk_r    <= arm_lk_nxt;
      arm_md_r    <= arm_md_nxt;
      mask_r      <= mask_nxt;
      access_en_r <= access_en_nxt;
      route_r     <= route_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command gating toward the sequencer
  assign op.go       = cmd_valid_in & rewrite_r & ~stop_r;
  assign op.kind     = cmd_kind_in;
  assign op.blk      = cmd_block_in;
  assign op.lock_off = lock_off_r;
  assign op.stop     = stop_r;
  assign op.op_done  = op_done_in;
  assign op.op_fail  = op_fail_in;

  flash_op_seq u_seq (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .op          (op.seq)
  );

  flash_irq u_irq (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .ev_in       (op.ev),
    .clr_in      (rd_stat),
    .mask_in     (mask_r),
    .status_out  (status),
    .irq_out     (irq_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // read path; reserved bit and unmapped addresses read zero
  always_comb begin
    ctl0_view = {op.erase_err, op.prog_err, area_r, 1'b0,
                 stop_r, lock_off_r, rewrite_r, op.ready};
    rd_data_nxt = 8'h00;
    if (rd_en_in) begin
      if (addr_in == `CTL0_ADDR) begin
        rd_data_nxt = ctl0_view;
      end else if (addr_in == `CTL1_ADDR) begin
        rd_data_nxt = {6'h00, mode_one_r, 1'b0};
      end else if (addr_in == `IRQ_STAT_ADDR) begin
        rd_data_nxt = {5'h00, status};
      end else if (addr_in == `IRQ_MASK_ADDR) begin
        rd_data_nxt = {5'h00, mask_r};
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= rd_data_nxt;
    end
  end

  // outputs that come from sequencer or control flops
  assign op_start_out        = op.start;
  assign op_kind_out         = op.cur_kind;
  assign op_block_out        = op.cur_blk;
  assign flash_stop_out      = stop_r;
  assign flash_access_en_out = access_en_r;
  assign user_area_route_out = route_r;
  assign rewrite_mode_out    = rewrite_r;
  assign lock_off_out        = lock_off_r;
  assign mode_one_out        = mode_one_r;
  assign lock_result_out     = op.lock_result;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  chk_busy_on_start: assert property (
    op_start_out |-> !op.ready ##1 (!op.ready || $past(op_done_in) || $past(stop_r)))
    else $error("ready shown while operation starts");
  chk_lock_read_busy: assert property (
    (op_start_out && op_kind_out == OP_LOCK_READ) |-> !op.ready)
    else $error("lock read not shown busy");
  chk_cmd_gate: assert property (
    op_start_out |-> $past(rewrite_r && !stop_r && cmd_valid_in))
    else $error("command started without rewrite enable");
  chk_rewrite_seq: assert property (
    $rose(rewrite_r) |-> $past(wr_ctl0 && wr_data_in[`B_REWRITE] && arm_rw_r))
    else $error("rewrite enable set without zero first");
  chk_stop_halts: assert property (
    stop_r |=> op.ready && !op_start_out)
    else $error("flash kept running while stopped");
  chk_stop_blocks: assert property (
    stop_r |-> !flash_access_en_out)
    else $error("array reachable while stopped");
  chk_area_route: assert property (
    !$past(rst_in) |-> user_area_route_out == (!$past(boot_mode_in) || area_r))
    else $error("area routing wrong");
  chk_mode_select: assert property (
    $rose(mode_one_r) |-> $past(wr_ctl1 && arm_md_r && rewrite_r))
    else $error("mode one set out of order");
  chk_rsvd_zero: assert property (
    (rd_en_in && addr_in == `CTL0_ADDR) |=> rd_data_out[`B_RSVD] == 1'b0)
    else $error("reserved bit read nonzero");
  chk_err_visible: assert property (
    (rd_en_in && addr_in == `CTL0_ADDR)
      |=> rd_data_out[`B_PROG_ERR] == $past(op.prog_err))
    else $error("program flag not shown");
endmodule : flash_control_status_register

// ---- design/flash_irq.sv ----
// sticky interrupt status with masked level output
// assumes: events are one-cycle pulses; clr_in pulses on a status read
`timescale 1ns/10ps
`include "flash_ctl_map.svh"
module flash_irq (
  input  wire logic              core_clk_in,  // system clock
  input  wire logic              rst_in,       // async reset, high
  input  wire logic [`EV_W-1:0]  ev_in,        // event pulses
  input  wire logic              clr_in,       // status read clears
  input  wire logic [`EV_W-1:0]  mask_in,      // enable per event
  output logic      [`EV_W-1:0]  status_out,   // sticky status
  output logic                   irq_out       // level interrupt
);
  logic [`EV_W-1:0] status_r;
  logic [`EV_W-1:0] status_nxt;
  logic             irq_nxt;

  // per bit: a new event beats a clear in the same cycle
  genvar i;
  for (i = 0; i < `EV_W; i = i + 1) begin : g_bit
    assign status_nxt[i] = ev_in[i] | (status_r[i] & ~clr_in);
  end

  // level from next values keeps irq aligned with status
  always_comb begin
    irq_nxt = |(status_nxt & mask_in);
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_r <= '0;
      irq_out  <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_out  <= irq_nxt;
    end
  end

  assign status_out = status_r;
endmodule : flash_irq

// ---- design/flash_op_seq.sv ----
// flash operation sequencer: lock bits, busy tracking, result flags
// assumes: the array answers each start with exactly one op_done pulse
`timescale 1ns/10ps
`include "flash_ctl_map.svh"
module flash_op_seq (
  input  wire logic core_clk_in,  // system clock
  input  wire logic rst_in,       // async reset, high
  flash_op_if.seq   op            // command and status carrier
);
  import flash_ctl_pkg::*;

  seq_state_t state_r, state_nxt;
  op_kind_t   kind_r, kind_nxt;
  logic [2:0] blk_r, blk_nxt;
  logic [7:0] lock_r, lock_nxt;   // 0 locked, 1 unlocked
  logic       perr_r, perr_nxt;
  logic       eerr_r, eerr_nxt;
  logic       lres_r, lres_nxt;
  logic       start_r, start_nxt;
  logic       ready_r, ready_nxt;
  logic [2:0] ev_r, ev_nxt;
  logic       blocked;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    blocked   = ~lock_r[op.blk] & ~op.lock_off &
                (op.kind == OP_PROGRAM || op.kind == OP_ERASE);
    state_nxt = state_r;
    kind_nxt  = kind_r;
    blk_nxt   = blk_r;
    lock_nxt  = lock_r;
    perr_nxt  = perr_r;
    eerr_nxt  = eerr_r;
    lres_nxt  = lres_r;
    start_nxt = 1'b0;
    ev_nxt    = '0;
    case (state_r)
      ST_IDLE: begin
        if (op.go) begin
          kind_nxt = op.kind;
          blk_nxt  = op.blk;
          if (blocked) begin
            // locked block: end in error without touching the array
            perr_nxt = (op.kind == OP_PROGRAM) ? 1'b1 : perr_r;
            eerr_nxt = (op.kind == OP_ERASE) ? 1'b1 : eerr_r;
            ev_nxt   = {op.kind == OP_ERASE, op.kind == OP_PROGRAM, 1'b1};
          end else begin
            start_nxt = 1'b1;
            state_nxt = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (op.op_done) begin
          state_nxt        = ST_IDLE;
          ev_nxt[`EV_DONE] = 1'b1;
          case (kind_r)
            OP_PROGRAM, OP_LOCK_PROG: begin
              perr_nxt         = op.op_fail;
              ev_nxt[`EV_PROG] = op.op_fail;
              if (kind_r == OP_LOCK_PROG && !op.op_fail) begin
                lock_nxt[blk_r] = 1'b0;
              end
            end
            OP_ERASE: begin
              eerr_nxt          = op.op_fail;
              ev_nxt[`EV_ERASE] = op.op_fail;
              if (!op.op_fail && op.lock_off) begin
                lock_nxt[blk_r] = 1'b1;
              end
            end
            default: begin
              lres_nxt = lock_r[blk_r];
            end
          endcase
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // stop resets the control circuit and abandons any operation
    if (op.stop) begin
      state_nxt = ST_IDLE;
      start_nxt = 1'b0;
    end
    ready_nxt = (state_nxt == ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      kind_r  <= OP_PROGRAM;
      blk_r   <= 3'h0;
      lock_r  <= `LOCK_RESET;
      perr_r  <= 1'b0;
      eerr_r  <= 1'b0;
      lres_r  <= 1'b0;
      start_r <= 1'b0;
      ready_r <= 1'b1;
      ev_r    <= '0;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      blk_r   <= blk_nxt;
      lock_r  <= lock_nxt;
      perr_r  <= perr_nxt;
      eerr_r  <= eerr_nxt;
      lres_r  <= lres_nxt;
      start_r <= start_nxt;
      ready_r <= ready_nxt;
      ev_r    <= ev_nxt;
    end
  end

  assign op.ready       = ready_r;
  assign op.prog_err    = perr_r;
  assign op.erase_err   = eerr_r;
  assign op.lock_result = lres_r;
  assign op.start       = start_r;
  assign op.cur_kind    = kind_r;
  assign op.cur_blk     = blk_r;
  assign op.ev          = ev_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_lock_refused: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state_r == ST_IDLE && op.go && !op.stop && blocked)
      |=> !start_r && (perr_r || eerr_r))
    else $error("locked block was started");
  chk_erase_unlock: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state_r == ST_RUN && op.op_done && !op.op_fail && !op.stop &&
     kind_r == OP_ERASE && op.lock_off) |=> lock_r[blk_r])
    else $error("erase did not unlock block");
  chk_prog_result: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state_r == ST_RUN && op.op_done && !op.stop && kind_r == OP_PROGRAM)
      |=> perr_r == $past(op.op_fail))
    else $error("program flag does not match result");
endmodule : flash_op_seq

// ---- dv/test_flash_control_status_register.sv ----
// self-checking bench for the flash control/status register block
// assumes: flash_ctl_pkg and the design compiled first, map header on the include path
`timescale 1ns/10ps
`include "flash_ctl_map.svh"
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", what, exp, got); end end
module test_flash_control_status_register;
  import flash_ctl_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0]  wr_data_in = 8'h00;
  logic        wr_en_in = 1'b0, rd_en_in = 1'b0, boot_mode_in = 1'b0;
  logic        cmd_valid_in = 1'b0, op_done_in = 1'b0, op_fail_in = 1'b0;
  op_kind_t    cmd_kind_in = OP_PROGRAM;
  logic [2:0]  cmd_block_in = 3'h0;
  logic [7:0]  rd_data_out;
  logic        irq_out, op_start_out, flash_stop_out, flash_access_en_out;
  logic        user_area_route_out, rewrite_mode_out, lock_off_out, mode_one_out;
  logic        lock_result_out;
  op_kind_t    op_kind_out;
  logic [2:0]  op_block_out;
  int          n_mismatch = 0;
  int          check_count = 0;

  // 250 MHz core clock
  always #2 core_clk_in = ~core_clk_in;

  flash_control_status_register dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .irq_out(irq_out), .boot_mode_in(boot_mode_in),
    .cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in), .cmd_block_in(cmd_block_in),
    .op_done_in(op_done_in), .op_fail_in(op_fail_in), .op_start_out(op_start_out),
    .op_kind_out(op_kind_out), .op_block_out(op_block_out), .flash_stop_out(flash_stop_out),
    .flash_access_en_out(flash_access_en_out), .user_area_route_out(user_area_route_out),
    .rewrite_mode_out(rewrite_mode_out), .lock_off_out(lock_off_out),
    .mode_one_out(mode_one_out), .lock_result_out(lock_result_out));

  ////////////////////////////////////////////////////////////////////////////////
  // idle cycles, then step past the edge so registered outputs have landed
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : idle

  // one-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_in <= a; wr_data_in <= d; wr_en_in <= 1'b1;
    @(posedge core_clk_in);
    wr_en_in <= 1'b0;
  endtask : wr

  // one-cycle read strobe; data stands only in the following cycle
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    addr_in <= a; rd_en_in <= 1'b1;
    @(posedge core_clk_in);
    rd_en_in <= 1'b0;
    #1;
    `CHK("read data", exp, rd_data_out)
  endtask : rdchk

  // command pulse; start is seen in the cycle after it or not at all
  task automatic cmd(input op_kind_t k, input logic [2:0] b, input logic exp);
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b1; cmd_kind_in <= k; cmd_block_in <= b;
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b0;
    #1;
    `CHK("op start", exp, op_start_out)
    if (exp) begin
      `CHK("op kind", k, op_kind_out)
      `CHK("op block", b, op_block_out)
    end
  endtask : cmd

  // array completion pulse with its failure flag
  task automatic done(input logic fail);
    @(posedge core_clk_in);
    op_done_in <= 1'b1; op_fail_in <= fail;
    @(posedge core_clk_in);
    op_done_in <= 1'b0; op_fail_in <= 1'b0;
    idle(3);
  endtask : done

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard: a stuck sequence counts as a mismatch
  initial begin
    #40000;
    n_mismatch++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    idle(2);
    `CHK("stop", 1'b0, flash_stop_out)
    `CHK("access", 1'b1, flash_access_en_out)
    rdchk(`CTL0_ADDR, 8'h01);
    rdchk(`CTL1_ADDR, 8'h00);
    rdchk(16'h0100, 8'h00);
    wr(`IRQ_MASK_ADDR, 8'h07);
    // a lone write of one must not arm rewrite mode
    wr(`CTL0_ADDR, 8'h02);
    rdchk(`CTL0_ADDR, 8'h01);
    cmd(OP_PROGRAM, 3'h0, 1'b0);
    wr(`CTL0_ADDR, 8'h00);
    wr(`CTL0_ADDR, 8'h02);
    wr(`CTL0_ADDR, 8'h06);
    idle(2);
    `CHK("rewrite", 1'b1, rewrite_mode_out)
    `CHK("lock off", 1'b1, lock_off_out)
    wr(`CTL0_ADDR, 8'h06);
    rdchk(`CTL0_ADDR, 8'h07);
    // lock block 3, read its lock state, then erase it with locks ignored
    cmd(OP_LOCK_PROG, 3'h3, 1'b1);
    rdchk(`CTL0_ADDR, 8'h06);
    done(1'b0);
    cmd(OP_LOCK_READ, 3'h3, 1'b1);
    rdchk(`CTL0_ADDR, 8'h06);
    done(1'b0);
    `CHK("lock result", 1'b0, lock_result_out)
    cmd(OP_ERASE, 3'h3, 1'b1);
    rdchk(`CTL0_ADDR, 8'h06);
    done(1'b1);
    rdchk(`CTL0_ADDR, 8'h87);
    `CHK("irq", 1'b1, irq_out)
    rdchk(`IRQ_STAT_ADDR, 8'h05);
    idle(2);
    `CHK("irq clr", 1'b0, irq_out)
    cmd(OP_ERASE, 3'h3, 1'b1);
    done(1'b0);
    cmd(OP_LOCK_READ, 3'h3, 1'b1);
    done(1'b0);
    `CHK("lock result", 1'b1, lock_result_out)
    cmd(OP_PROGRAM, 3'h1, 1'b1);
    done(1'b1);
    rdchk(`CTL0_ADDR, 8'h47);
    // honour locks again: a locked block refuses programming
    wr(`CTL0_ADDR, 8'h02);
    cmd(OP_LOCK_PROG, 3'h5, 1'b1);
    done(1'b0);
    cmd(OP_PROGRAM, 3'h5, 1'b0);
    rdchk(`CTL0_ADDR, 8'h43);
    wr(`CTL1_ADDR, 8'h00);
    wr(`CTL1_ADDR, 8'h02);
    idle(2);
    `CHK("mode one", 1'b1, mode_one_out)
    rdchk(`CTL1_ADDR, 8'h02);
    // area routing only matters in boot mode
    @(posedge core_clk_in);
    boot_mode_in <= 1'b1;
    wr(`CTL0_ADDR, 8'h22);
    idle(2);
    `CHK("area", 1'b1, user_area_route_out)
    wr(`CTL0_ADDR, 8'h02);
    idle(2);
    `CHK("area", 1'b0, user_area_route_out)
    @(posedge core_clk_in);
    boot_mode_in <= 1'b0;
    idle(2);
    `CHK("area", 1'b1, user_area_route_out)
    // stop bit blocks the array and drops commands
    wr(`CTL0_ADDR, 8'h0a);
    idle(2);
    `CHK("stop", 1'b1, flash_stop_out)
    `CHK("access", 1'b0, flash_access_en_out)
    cmd(OP_PROGRAM, 3'h0, 1'b0);
    wr(`CTL0_ADDR, 8'h00);
    idle(2);
    `CHK("rewrite", 1'b0, rewrite_mode_out)
    `CHK("stop", 1'b0, flash_stop_out)
    finish_test();
  end
endmodule : test_flash_control_status_register
